// *** src/dlgc_pkg.sv ***
package dlgc_pkg;
    // Frame layout
    localparam int FRAME_BITS     = 16;
    localparam int CNT_W          = 5;
    localparam int POS_IGNORE     = 15;
    localparam int POS_BUF        = 14;
    localparam int POS_GAIN       = 13;
    localparam int POS_ACTIVE     = 12;
    localparam int DATA_TOP       = 11;
    // Reset values of the configuration, and the bit count of a full frame
    localparam logic GAIN_N_RST   = 1'h0;
    localparam logic BUF_RST      = 1'h0;
    localparam logic ACTIVE_RST   = 1'h0;
    localparam logic [4:0] FRAME_CNT = 5'h10;
endpackage

// *** src/dlgc_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
module dlgc_sync #(
    parameter int               WIDTH   = 4,
    parameter logic [WIDTH-1:0] RST_VAL = '0 // Level held while in reset
) (
    input  wire logic             clk,    // Sampling clock
    input  wire logic             rst,    // Synchronous reset
    input  wire logic [WIDTH-1:0] din,    // Asynchronous inputs
    output logic      [WIDTH-1:0] dout    // Synchronised inputs
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } dlgc_sync_t;

    dlgc_sync_t st;
    dlgc_sync_t next_st;

    // Two-stage chain; the first stage feeds only the second
    always_comb begin
        next_st      = st;
        next_st.meta = din;
        next_st.sync = st.meta;
    end

    // Stages start at the idle levels of the pins
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '{meta: RST_VAL, sync: RST_VAL};
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.sync;
endmodule
`default_nettype wire

// *** src/dlgc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module dlgc_top #(
    parameter int CODE_W = 12
) (
    input  wire logic              CORE_CLK,     // 100 MHz clock
    input  wire logic              RST,          // Synchronous reset
    input  wire logic              CS_N,         // Chip select pin
    input  wire logic              SCK,          // Serial clock pin
    input  wire logic              SDI,          // Serial data pin
    input  wire logic              OUTPUT_LOAD_STROBE_N, // Load strobe
    output logic      [CODE_W-1:0] DAC_CODE,     // Converter code
    output logic                   GAIN_SELECT_N, // Gain, 0 is 2x
    output logic                   REF_BUFFERED, // Reference buffer on
    output logic                   OUT_ACTIVE,   // Output amp enabled
    output logic                   WORD_TAKEN    // Input reg loaded pulse
);
    typedef struct packed {
        logic                  cs_d;
        logic                  sck_d;
        logic [dlgc_pkg::CNT_W-1:0]      cnt;
        logic [dlgc_pkg::FRAME_BITS-1:0] shift;
        logic [CODE_W-1:0]     in_code;
        logic                  in_gain_n;
        logic                  in_buf;
        logic                  in_active;
        logic [CODE_W-1:0]     out_code;
        logic                  out_gain_n;
        logic                  out_buf;
        logic                  out_active;
        logic                  taken;
    } dlgc_state_t;

    dlgc_state_t st;
    dlgc_state_t next_st;
    // Synchronised pins and their idle levels, chip select and strobe high
    localparam int               PIN_N    = 4;
    localparam logic [PIN_N-1:0] PIN_IDLE = 4'h9;
    logic [PIN_N-1:0] pins_s;
    logic        cs_n_s;
    logic        sck_s;
    logic        sdi_s;
    logic        load_n_s;
    logic        sck_rise;
    logic        cs_rise;

    // Bring the pins into the core clock domain; the stages start at the
    // idle levels so that no false chip select edge follows reset
    dlgc_sync #(
        .WIDTH   (PIN_N),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .clk  (CORE_CLK),
        .rst  (RST),
        .din  ({CS_N, SCK, SDI, OUTPUT_LOAD_STROBE_N}),
        .dout (pins_s)
    );

    assign cs_n_s   = pins_s[3];
    assign sck_s    = pins_s[2];
    assign sdi_s    = pins_s[1];
    assign load_n_s = pins_s[0];
    // Edge detection on the synchronised pins
    assign sck_rise = sck_s & ~st.sck_d & ~cs_n_s;
    assign cs_rise  = cs_n_s & ~st.cs_d;

    // A closing frame is taken only when complete and not marked ignore
    function automatic logic word_ok(
        input logic [dlgc_pkg::CNT_W-1:0]      cnt,
        input logic [dlgc_pkg::FRAME_BITS-1:0] word
    );
        return (cnt == dlgc_pkg::FRAME_CNT) &&
               !word[dlgc_pkg::POS_IGNORE];
    endfunction

    // Frame capture, input register and output register
    always_comb begin
        next_st       = st;
        next_st.cs_d  = cs_n_s;
        next_st.sck_d = sck_s;
        next_st.taken = 1'b0;
        if (sck_rise && st.cnt < dlgc_pkg::FRAME_CNT) begin
            next_st.shift = {st.shift[dlgc_pkg::FRAME_BITS-2:0],
                             sdi_s};
            next_st.cnt   = st.cnt + 5'h01;
        end
        if (cs_n_s && !cs_rise) begin
            next_st.cnt = '0;
        end
        if (cs_rise) begin
            next_st.cnt = '0;
            if (word_ok(st.cnt, st.shift)) begin
                next_st.in_code   = st.shift[dlgc_pkg::DATA_TOP -:
                                             CODE_W];
                next_st.in_gain_n = st.shift[dlgc_pkg::POS_GAIN];
                next_st.in_buf    = st.shift[dlgc_pkg::POS_BUF];
                next_st.in_active = st.shift[dlgc_pkg::POS_ACTIVE];
                next_st.taken     = 1'b1;
            end
        end
        // Transparent transfer while the strobe is low
        if (!load_n_s) begin
            next_st.out_code   = next_st.in_code;
            next_st.out_gain_n = next_st.in_gain_n;
            next_st.out_buf    = next_st.in_buf;
            next_st.out_active = next_st.in_active;
        end
    end

    // State register
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            st            <= '{default: '0};
            st.cs_d       <= 1'b1;
            st.in_gain_n  <= dlgc_pkg::GAIN_N_RST;
            st.out_gain_n <= dlgc_pkg::GAIN_N_RST;
            st.in_buf     <= dlgc_pkg::BUF_RST;
            st.out_buf    <= dlgc_pkg::BUF_RST;
            st.in_active  <= dlgc_pkg::ACTIVE_RST;
            st.out_active <= dlgc_pkg::ACTIVE_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from flip-flops
    assign DAC_CODE      = st.out_code;
    assign GAIN_SELECT_N = st.out_gain_n;
    assign REF_BUFFERED  = st.out_buf;
    assign OUT_ACTIVE    = st.out_active;
    assign WORD_TAKEN    = st.taken;

    // Frame counter never passes sixteen
    a_count_bound: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        st.cnt <= dlgc_pkg::FRAME_CNT)
        else $error("count over 16");
    // No counting while chip select high
    a_idle_cs: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        cs_n_s && st.cs_d |=> st.cnt == '0)
        else $error("count idle");
    // Short frame leaves input register untouched
    a_short_drop: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        cs_rise && st.cnt != dlgc_pkg::FRAME_CNT |=>
        $stable(st.in_code) && !st.taken)
        else $error("short frame loaded");
    // Ignore bit blocks loading
    a_ignore_word: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        cs_rise && st.shift[dlgc_pkg::POS_IGNORE] |=> !st.taken)
        else $error("ignored word loaded");
    // Full valid frame loads
    a_full_load: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        cs_rise && st.cnt == dlgc_pkg::FRAME_CNT &&
        !st.shift[dlgc_pkg::POS_IGNORE] |=> st.taken)
        else $error("valid word lost");
    // Strobe low makes output follow
    a_strobe_copy: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !load_n_s |=> st.out_code == st.in_code &&
        st.out_gain_n == st.in_gain_n)
        else $error("no transfer");
    // Strobe high holds output
    a_strobe_hold: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        load_n_s |=> $stable(st.out_code) && $stable(st.out_gain_n))
        else $error("output moved");
    // Strobe tied low: taken word reaches the output with it
    sequence s_take_low;
        !load_n_s ##1 st.taken;
    endsequence
    a_tied_low: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_take_low |-> st.out_code == st.in_code)
        else $error("no update at cs rise");
    // Shift happens only on a qualified serial edge
    a_shift_edge: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !sck_rise |=> $stable(st.shift))
        else $error("stray shift");
    // Fields of the word held in the shifter, for the load checks
    logic [CODE_W-1:0] word_code;
    logic              word_gain_n;
    assign word_code   = st.shift[dlgc_pkg::DATA_TOP -: CODE_W];
    assign word_gain_n = st.shift[dlgc_pkg::POS_GAIN];
    // A closing frame that is complete and not marked ignore
    sequence s_word_close;
        cs_rise && word_ok(st.cnt, st.shift);
    endsequence
    // Load flag high for exactly one cycle
    sequence s_one_pulse;
        st.taken ##1 !st.taken;
    endsequence
    a_taken_pulse: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_word_close |=> s_one_pulse)
        else $error("load pulse not single");
    // Data field lands unchanged in the input register
    a_code_map: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_word_close |=> st.in_code == $past(word_code))
        else $error("code field misplaced");
    // Gain bit lands unchanged in the input register
    a_gain_map: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        s_word_close |=> st.in_gain_n == $past(word_gain_n))
        else $error("gain bit misplaced");
    // Input register moves only when a frame closes
    a_in_hold: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !cs_rise |=> $stable(st.in_code) && $stable(st.in_gain_n))
        else $error("input register moved");
    // Serial activity is ignored while deselected
    a_cs_noshift: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        cs_n_s |=> $stable(st.shift))
        else $error("shift while deselected");
    // Clocks after the sixteenth leave the word alone
    a_past_full: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        st.cnt == dlgc_pkg::FRAME_CNT |=> $stable(st.shift))
        else $error("shift past sixteen");
    // Gain leaves reset at double gain
    a_gain_reset: assert property (
        @(posedge CORE_CLK)
        $fell(RST) |-> st.out_gain_n == dlgc_pkg::GAIN_N_RST &&
        st.in_gain_n == dlgc_pkg::GAIN_N_RST)
        else $error("gain not at reset value");
    // Only the three supported code widths are built
    a_code_width: assert property (
        @(posedge CORE_CLK)
        CODE_W == 8 || CODE_W == 10 || CODE_W == 12)
        else $error("illegal code width");
endmodule
`default_nettype wire

// *** testbench/dlgc_master.sv ***
`timescale 1ns/10ps
`default_nettype none
// SPI master and load strobe that drive the converter's pins
module dlgc_master (
    output logic cs_n, // Chip select
    output logic sck,  // Serial clock, still between frames
    output logic sdi,  // Serial data
    output logic ld_n  // Output load strobe
);
    // Idle pins until the bench starts a transfer
    initial begin
        cs_n = 1'h1;
        sck = 1'h0;
        sdi = 1'h0;
        ld_n = 1'h1;
    end
    // One frame of nclk clocks at 125 ns; sel low leaves chip select high
    task automatic send(input logic [15:0] w, input int nclk, input logic sel);
        cs_n <= ~sel;
        for (int i = 0; i < nclk; i++) begin
            sdi <= (i < 16) ? w[15 - i] : ~sdi;
            #62.5;
            sck <= 1'h1;
            #62.5;
            sck <= 1'h0;
        end
        #62.5;
        cs_n <= 1'h1;
        sdi <= ~sdi; // Released line must not show a stale bit
    endtask
    // Level of the load strobe
    task automatic load(input logic v);
        ld_n <= v;
    endtask
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam int CW = 10;
    logic          clk;
    logic          rst;
    wire logic     cs_n, sck, sdi, ld_n;
    logic [CW-1:0] code;
    logic          gain, bufd, act, taken;
    int            err_total, comparisons, seen, exp_taken;
    logic [15:0]   in_reg, out_reg;
    logic [31:0]   seed;
    dlgc_master dlgc_master_i (.cs_n(cs_n), .sck(sck), .sdi(sdi), .ld_n(ld_n));
    dlgc_top #(.CODE_W(CW)) dlgc_top_i (.CORE_CLK(clk), .RST(rst),
        .CS_N(cs_n), .SCK(sck), .SDI(sdi), .OUTPUT_LOAD_STROBE_N(ld_n),
        .DAC_CODE(code), .GAIN_SELECT_N(gain), .REF_BUFFERED(bufd),
        .OUT_ACTIVE(act), .WORD_TAKEN(taken));
    // Clock and load pulse counter
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) if (taken === 1'h1) seen++;
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input string what, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    // Outputs against the model's output register and load count
    task automatic check_outputs();
        check("code", (out_reg >> (12 - CW)) & ((16'h1 << CW) - 16'h1),
              16'(code));
        check("gain", 16'(out_reg[13]), 16'(gain));
        check("buffer", 16'(out_reg[14]), 16'(bufd));
        check("active", 16'(out_reg[12]), 16'(act));
        check("taken", 16'(exp_taken), 16'(seen));
    endtask
    // Send a frame, update the model, then compare once settled
    task automatic frame(input logic [15:0] w, input int n, input logic sel);
        dlgc_master_i.send(w, n, sel);
        if (sel && n >= 16 && w[15] == 1'h0) begin
            in_reg = w;
            exp_taken++;
        end
        if (ld_n == 1'h0) out_reg = in_reg;
        repeat (10) @(posedge clk);
        check_outputs();
    endtask
    task automatic strobe(input logic v);
        dlgc_master_i.load(v);
        if (!v) out_reg = in_reg;
        repeat (10) @(posedge clk);
        check_outputs();
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog well beyond the expected run of about 44 us
    initial begin
        #500000;
        err_total++;
        report_and_stop();
    end
    // Main sequence
    initial begin
        rst = 1'h1;
        seed = 32'hA868;
        {err_total, comparisons, seen, exp_taken} = '0;
        {in_reg, out_reg} = '0;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        repeat (5) @(posedge clk);
        check_outputs();
        strobe(1'h0);
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            frame(seed[15:0], 16, 1'h1);
        end
        frame(16'h3FFF, 16, 1'h1);
        frame(16'h1000, 16, 1'h1);
        frame(16'hB5A5, 16, 1'h1);
        frame(16'h2ABC, 15, 1'h1);
        frame(16'h5678, 17, 1'h1);
        frame(16'h0FFF, 16, 1'h0);
        strobe(1'h1);
        frame(16'h3C3C, 16, 1'h1);
        frame(16'h4321, 16, 1'h1);
        strobe(1'h0);
        frame(16'h7ABC, 16, 1'h1);
        rst <= 1'h1;
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        {in_reg, out_reg} = '0;
        repeat (5) @(posedge clk);
        check_outputs();
        frame(16'h1234, 16, 1'h1);
        report_and_stop();
    end
endmodule
`default_nettype wire
